/* core/frt_pkg.sv */
// Holds the register map, field positions, reset values and count divider figures of the timer.
// Assumes a 32-bit Avalon-MM slave with word addressing in bytes and a 20 MHz system clock.
package frt_pkg;
  localparam logic [7:0] off_mode_ctrl = 8'h00;
  localparam logic [7:0] off_match = 8'h04;
  localparam logic [7:0] off_count = 8'h08;
  localparam logic [7:0] off_count_lo = 8'h0c;
  localparam logic [7:0] off_count_hi = 8'h10;
  localparam logic [7:0] off_latched = 8'h14;
  localparam logic [7:0] off_irq_mask = 8'h18;
  localparam logic [7:0] off_port = 8'h1c;
  localparam logic [7:0] off_irq_pend = 8'h20;
  localparam int bit_pin_drive_enable = 0;
  localparam int bit_clk_div_sel_lo = 1;
  localparam int bit_clk_div_sel_hi = 2;
  localparam int bit_toggle_allow = 3;
  localparam int bit_edge_sel_lo = 4;
  localparam int bit_edge_sel_hi = 5;
  localparam int bit_wrap_flag = 6;
  localparam int bit_pin_level = 7;
  localparam int bit_match_mask = 7;
  localparam int bit_port_out = 0;
  localparam int bit_port_dir = 1;
  localparam logic [7:0] mode_ctrl_reset = 8'h00;
  localparam logic [15:0] match_reset = 16'hffff;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] irq_mask_reset = 8'hff;
  localparam logic [1:0] port_reset = 2'h2;
  localparam logic [1:0] div_sel_4 = 2'h0;
  localparam logic [1:0] div_sel_64 = 2'h1;
  localparam int div_4_cycles = 4;
  localparam int div_64_cycles = 64;
  localparam logic [1:0] edge_none = 2'h0;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_fall = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;
endpackage

/* core/count_divider.sv */
// Holds the divider that makes the count enable pulse from the system clock.
// Assumes one clock; a prohibited select code gives no pulse at all.
`timescale 1ns/1ps
`default_nettype none
module count_divider (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] div_sel,
  output logic tick
);
  typedef struct packed {
    logic [5:0] prescale;
  } div_state_t;
  div_state_t state, next_state;
  always_comb begin
    next_state = state;
    next_state.prescale = state.prescale + 6'h01;
    tick = 1'b0;
    case (div_sel)
      frt_pkg::div_sel_4: tick = (state.prescale[1:0] == 2'(frt_pkg::div_4_cycles - 1)); // see RULE4
      frt_pkg::div_sel_64: tick = (state.prescale == 6'(frt_pkg::div_64_cycles - 1)); // see RULE4
      default: tick = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

/* core/capture_edge.sv */
// Holds the capture trigger edge detector.
// Assumes the trigger pin is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module capture_edge (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic capture_trigger_pin,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  typedef struct packed {
    logic last;
  } edge_state_t;
  edge_state_t state, next_state;
  logic rise;
  logic fall;
  always_comb begin
    next_state.last = capture_trigger_pin;
    rise = capture_trigger_pin & ~state.last;
    fall = ~capture_trigger_pin & state.last;
    case (edge_sel)
      frt_pkg::edge_rise: hit = rise; // see RULE10
      frt_pkg::edge_fall: hit = fall; // see RULE10
      frt_pkg::edge_both: hit = rise | fall; // see RULE10
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

/* core/free_running_timer_compare_capture.sv */
// Holds the free-running timer with compare, toggle output, capture and buffered count readout.
// Assumes an Avalon-MM master on mclk; the pin buffer outside resolves the shared pin from its enable.
//
// Contract
// RULE1 - Software masks the match interrupt before changing the compare value while counting.
// RULE2 - Software clears toggle enable before changing the compare value while counting.
// RULE3 - A compare write with the interrupt unmasked may raise a match request.
// RULE4 - Clock select 00 divides the clock by 4, 01 by 64; others prohibited.
// RULE5 - Matches repeat one full 65536-count wrap apart.
// RULE6 - With toggling enabled the output inverts on every match; counter not cleared.
// RULE7 - Every match keeps counting and raises the match interrupt request.
// RULE8 - Software sets the shared pin to output and its latch to zero first.
// RULE9 - The timer output starts low while output drive is enabled.
// RULE10 - Edge select: 00 off, 01 rising, 10 falling, 11 both edges.
// RULE11 - Capture takes the count within two clocks and holds it until next edge.
// RULE12 - Software disables capture edges while reading the capture register.
// RULE13 - A low-byte count read freezes the read buffer on the held value.
// RULE14 - A high-byte count read releases the buffer back to tracking.
// RULE15 - Reset clears the counter to zero, then it free-runs.
// RULE16 - Bytewise count reads go low then high, in pairs.
// RULE17 - The counter also accepts byte-wide reads in place of a 16-bit read.
// RULE18 - Count after leaving stop mode is undefined; nothing assumes a value.
// RULE19 - The wrap flag sets on counter overflow; reset or software write clears it.
// RULE20 - Output drive enable zero leaves the pin to the port; one drives it.
// RULE21 - The counter increments on each count tick and wraps to zero.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module free_running_timer_compare_capture #(
  parameter int count_width = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic capture_trigger_pin,
  input wire logic shared_port_in,
  output logic toggle_out_pin,
  output logic shared_port_out,
  output logic shared_port_oe,
  output logic match_irq
);
  typedef struct packed {
    logic [count_width-1:0] free_count;
    logic [count_width-1:0] match_value;
    logic [count_width-1:0] latched_count;
    logic [count_width-1:0] read_buffer;
    logic buffer_frozen;
    logic [7:0] timer_mode_ctrl;
    logic [7:0] irq_mask_reg;
    logic [1:0] port_ctrl;
    logic match_pend;
    logic capture_due;
    logic ack;
    logic [31:0] rdata;
    logic err;
  } timer_state_t;

  timer_state_t state, next_state;
  logic tick;
  logic hit;
  logic access;
  logic commit;
  logic match;
  logic [count_width-1:0] count_next;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  count_divider u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .div_sel({state.timer_mode_ctrl[frt_pkg::bit_clk_div_sel_hi], state.timer_mode_ctrl[frt_pkg::bit_clk_div_sel_lo]}),
    .tick(tick)
  );

  capture_edge u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .capture_trigger_pin(capture_trigger_pin),
    .edge_sel({state.timer_mode_ctrl[frt_pkg::bit_edge_sel_hi], state.timer_mode_ctrl[frt_pkg::bit_edge_sel_lo]}),
    .hit(hit)
  );

  // One wait cycle per access keeps the answer a registered one.
  assign access = (avs_read | avs_write) & ~state.ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~state.ack;
  // Writes land only at the edge that completes the transfer, where the master sees waitrequest low.
  assign commit = avs_write & state.ack;
  assign count_next = state.free_count + count_width'(1);

  always_comb begin
    logic [31:0] wmerge;
    wmerge = '0;
    next_state = state;
    next_state.ack = access;
    match = 1'b0;

    if (tick) begin
      next_state.free_count = count_next; // see RULE21 see RULE15 see RULE18
      if (state.free_count == {count_width{1'b1}}) begin
        next_state.timer_mode_ctrl[frt_pkg::bit_wrap_flag] = 1'b1; // see RULE19
      end
      // Comparing the new count gives one match per wrap, as the counter is never cleared.
      match = (count_next == state.match_value); // see RULE5 see RULE7
    end

    if (!state.buffer_frozen) begin
      next_state.read_buffer = state.free_count;
    end

    // The capture lands two clocks after the edge, at the close of the two-clock window.
    next_state.capture_due = hit;
    if (state.capture_due) begin
      next_state.latched_count = state.free_count; // see RULE11
    end

    if (commit) begin
      case (avs_address)
        frt_pkg::off_mode_ctrl: begin
          wmerge = lanes({24'h0, state.timer_mode_ctrl}, avs_writedata, avs_byteenable);
          next_state.timer_mode_ctrl[6:0] = wmerge[6:0];
          // Software may clear the flag, but an overflow in the same cycle wins.
          if (tick && state.free_count == {count_width{1'b1}}) begin
            next_state.timer_mode_ctrl[frt_pkg::bit_wrap_flag] = 1'b1; // see RULE19
          end
          if (wmerge[frt_pkg::bit_pin_drive_enable] && !state.timer_mode_ctrl[frt_pkg::bit_pin_drive_enable]) begin
            next_state.timer_mode_ctrl[frt_pkg::bit_pin_level] = 1'b0; // see RULE9
          end
        end
        frt_pkg::off_match: begin
          wmerge = lanes({16'h0, state.match_value}, avs_writedata, avs_byteenable);
          next_state.match_value = wmerge[count_width-1:0];
          // A rewrite that equals the running count flags a match at once.
          if (wmerge[count_width-1:0] == state.free_count) begin
            match = 1'b1; // see RULE3
          end
        end
        frt_pkg::off_irq_mask: begin
          wmerge = lanes({24'h0, state.irq_mask_reg}, avs_writedata, avs_byteenable);
          next_state.irq_mask_reg = wmerge[7:0]; // see RULE1
        end
        frt_pkg::off_port: begin
          wmerge = lanes({30'h0, state.port_ctrl}, avs_writedata, avs_byteenable);
          next_state.port_ctrl = wmerge[1:0]; // see RULE8
        end
        frt_pkg::off_irq_pend: begin
          if (avs_byteenable[0] && avs_writedata[0]) begin
            next_state.match_pend = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (match) begin
      next_state.match_pend = 1'b1; // see RULE7
      if (state.timer_mode_ctrl[frt_pkg::bit_toggle_allow]) begin
        next_state.timer_mode_ctrl[frt_pkg::bit_pin_level] = ~state.timer_mode_ctrl[frt_pkg::bit_pin_level]; // see RULE6 see RULE2
      end
    end

    next_state.err = 1'b0;
    if (access && avs_read) begin
      next_state.rdata = '0;
      case (avs_address)
        frt_pkg::off_mode_ctrl: next_state.rdata = {24'h0, state.timer_mode_ctrl};
        frt_pkg::off_match: next_state.rdata = {16'h0, state.match_value};
        frt_pkg::off_count: next_state.rdata = {16'h0, state.read_buffer}; // see RULE17
        frt_pkg::off_count_lo: begin
          next_state.rdata = {24'h0, state.read_buffer[7:0]}; // see RULE13 see RULE17
          // The buffer freezes on the value just handed out, so both bytes belong to one count.
          next_state.read_buffer = state.read_buffer; // see RULE13
          next_state.buffer_frozen = 1'b1; // see RULE13 see RULE16
        end
        frt_pkg::off_count_hi: begin
          next_state.rdata = {24'h0, state.read_buffer[15:8]}; // see RULE16
          next_state.buffer_frozen = 1'b0; // see RULE14
        end
        frt_pkg::off_latched: next_state.rdata = {16'h0, state.latched_count}; // see RULE12
        frt_pkg::off_irq_mask: next_state.rdata = {24'h0, state.irq_mask_reg};
        frt_pkg::off_port: next_state.rdata = {29'h0, shared_port_in, state.port_ctrl};
        frt_pkg::off_irq_pend: next_state.rdata = {31'h0, state.match_pend};
        default: next_state.err = 1'b1;
      endcase
    end else if (access && avs_write) begin
      next_state.err = (avs_address > frt_pkg::off_irq_pend) || (avs_address[1:0] != 2'h0);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state.free_count <= frt_pkg::count_reset; // see RULE15
      state.match_value <= frt_pkg::match_reset;
      state.latched_count <= '0;
      state.read_buffer <= '0;
      state.buffer_frozen <= 1'b0;
      state.timer_mode_ctrl <= frt_pkg::mode_ctrl_reset;
      state.irq_mask_reg <= frt_pkg::irq_mask_reset;
      state.port_ctrl <= frt_pkg::port_reset;
      state.match_pend <= 1'b0;
      state.capture_due <= 1'b0;
      state.ack <= 1'b0;
      state.rdata <= '0;
      state.err <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata = state.rdata;
  assign avs_response_err = state.err;
  assign match_irq = state.match_pend & ~state.irq_mask_reg[frt_pkg::bit_match_mask]; // see RULE1
  assign toggle_out_pin = state.timer_mode_ctrl[frt_pkg::bit_pin_level];
  // With drive enabled the timer level replaces the port latch on the pin.
  assign shared_port_out = state.timer_mode_ctrl[frt_pkg::bit_pin_drive_enable]
                           ? state.timer_mode_ctrl[frt_pkg::bit_pin_level]
                           : state.port_ctrl[frt_pkg::bit_port_out]; // see RULE20
  assign shared_port_oe = ~state.port_ctrl[frt_pkg::bit_port_dir];
endmodule
`default_nettype wire

/* test/frt_properties.sv */
// Assertions on the timer's bus answer, interrupt request and pin outputs.
// Assumes one clock, the one-wait answer of the register bus and a bind to the timer's top.
`timescale 1ns/1ps
`default_nettype none
module frt_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic toggle_out_pin,
  input wire logic shared_port_out,
  input wire logic shared_port_oe,
  input wire logic match_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("Request start had no wait cycle.");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Answer did not come after one wait.");
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("Wait raised with no request.");
  chk_read_unmapped: assert property (avs_read && !avs_waitrequest && avs_address > 8'h20
    |-> avs_response_err && avs_readdata == 32'h0) else $error("Unmapped read was not refused.");
  chk_read_mapped: assert property (avs_read && !avs_waitrequest && avs_address <= frt_pkg::off_irq_pend
    && avs_address[1:0] == 2'h0 |-> !avs_response_err) else $error("Mapped read was refused.");
  chk_irq_fall: assert property ($fell(match_irq) |-> $past(avs_write) && !$past(avs_waitrequest))
    else $error("Match request fell without a software write.");
  chk_oe_write: assert property ($changed(shared_port_oe)
    |-> $past(avs_write) && $past(avs_address) == frt_pkg::off_port) else $error("Pin enable moved by itself.");
  chk_out_cause: assert property ($changed(shared_port_out)
    |-> $changed(toggle_out_pin) || ($past(avs_write) && !$past(avs_waitrequest)))
    else $error("Shared pin moved without toggle or write.");
endmodule
bind free_running_timer_compare_capture frt_properties checker_i (.mclk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .avs_response_err, .toggle_out_pin, .shared_port_out,
  .shared_port_oe, .match_irq);
`default_nettype wire

/* test/cpu_bus_model.sv */
// Processor core model that issues register reads and writes to the timer over Avalon-MM.
// Assumes the timer answers on mclk by dropping waitrequest; the bench's watchdog ends any hang.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic mclk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  // Whole words only; byte reads of the count use their own direct offsets.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // The idle edge keeps a following request from reassigning the strobe in the same step.
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* test/free_running_timer_compare_capture_bench.sv */
// Self-checking bench of the timer: register transfers through the core model, pin stimulus and checks.
// Assumes the core model's transfer task and the checker bound to the timer.
`timescale 1ns/1ps
`default_nettype none
module free_running_timer_compare_capture_bench;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, avs_response_err, capture_trigger_pin;
  logic shared_port_in, toggle_out_pin, shared_port_out, shared_port_oe, match_irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, a, b;
  int n_fail, comparisons;
  cpu_bus_model cpu (.mclk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable);
  free_running_timer_compare_capture DUT (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .capture_trigger_pin, .shared_port_in,
    .toggle_out_pin, .shared_port_out, .shared_port_oe, .match_irq);
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    cpu.xfer(1'b0, ad, 32'h0, v);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    cpu.xfer(1'b1, ad, d, q);
  endtask
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches.", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // The tests take under 6000 clocks, so a much longer wait means a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    capture_trigger_pin = 1'b0;
    shared_port_in = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(frt_pkg::off_count, q);
    chk(q[15:0] < 16'h0003, "count after reset");
    rd(frt_pkg::off_match, q);
    chk(q[15:0] === frt_pkg::match_reset, "match reset");
    rd(frt_pkg::off_port, q);
    chk(q[2:0] === {1'b1, frt_pkg::port_reset} && shared_port_oe === 1'b0, "port reset");
    rd(8'h40, q);
    chk(q === 32'h0, "unmapped read");
    $display("Reset test ended.");
    // Ending on code 00 leaves the counter running for the later tests.
    for (int c = 2; c >= 0; c--) begin
      int e;
      wr(frt_pkg::off_mode_ctrl, {29'h0, c[1:0], 1'b0});
      rd(frt_pkg::off_count, a);
      repeat (637) @(posedge mclk);
      rd(frt_pkg::off_count, b);
      e = (c == 0) ? 640 / frt_pkg::div_4_cycles : (c == 1) ? 640 / frt_pkg::div_64_cycles : 0;
      chk(b[15:0] - a[15:0] === e[15:0], "ticks in 640 clocks");
    end
    $display("Divider test ended.");
    rd(frt_pkg::off_count_lo, a);
    repeat (40) @(posedge mclk);
    rd(frt_pkg::off_count, b);
    chk(b[7:0] === a[7:0], "count held after low byte");
    rd(frt_pkg::off_count_hi, q);
    chk(q === {24'h0, b[15:8]}, "high byte of held count");
    repeat (40) @(posedge mclk);
    rd(frt_pkg::off_count, q);
    chk(q[15:0] - b[15:0] > 16'h000a, "count tracking again");
    $display("Readout test ended.");
    wr(frt_pkg::off_port, 32'h1);
    chk(shared_port_oe === 1'b1 && shared_port_out === 1'b1, "port drives latch");
    wr(frt_pkg::off_port, 32'h0);
    wr(frt_pkg::off_mode_ctrl, 32'h1);
    chk(toggle_out_pin === 1'b0 && shared_port_out === 1'b0, "timer output starts low");
    rd(frt_pkg::off_count, a);
    wr(frt_pkg::off_match, {16'h0, a[15:0] + 16'h0014});
    wr(frt_pkg::off_mode_ctrl, 32'h9);
    wr(frt_pkg::off_irq_pend, 32'h1);
    wr(frt_pkg::off_irq_mask, 32'h0);
    for (int i = 0; i < 200 && match_irq !== 1'b1; i++) begin
      @(posedge mclk);
    end
    rd(frt_pkg::off_count, b);
    chk(match_irq === 1'b1 && b[15:0] - a[15:0] inside {[16'h0014:16'h0016]}, "match kept counting");
    rd(frt_pkg::off_mode_ctrl, q);
    chk(q[frt_pkg::bit_pin_level] === 1'b1 && shared_port_out === 1'b1, "output inverted");
    wr(frt_pkg::off_irq_mask, 32'h80);
    chk(match_irq === 1'b0, "masked request");
    wr(frt_pkg::off_irq_mask, 32'h0);
    chk(match_irq === 1'b1, "pending request shows again");
    wr(frt_pkg::off_irq_pend, 32'h1);
    chk(match_irq === 1'b0, "request cleared");
    repeat (2000) @(posedge mclk);
    chk(match_irq === 1'b0 && toggle_out_pin === 1'b1, "no repeat before a wrap");
    // A prohibited divider code stops the count, so the rewrite can hit the running value exactly.
    wr(frt_pkg::off_mode_ctrl, 32'h5);
    rd(frt_pkg::off_count, a);
    wr(frt_pkg::off_match, a);
    chk(match_irq === 1'b1 && toggle_out_pin === 1'b1, "match on compare rewrite");
    wr(frt_pkg::off_irq_pend, 32'h1);
    wr(frt_pkg::off_mode_ctrl, 32'h4);
    wr(frt_pkg::off_mode_ctrl, 32'h5);
    chk(toggle_out_pin === 1'b0 && match_irq === 1'b0, "output low again on drive enable");
    $display("Compare test ended.");
    for (int e = 0; e < 4; e++) begin
      wr(frt_pkg::off_mode_ctrl, {26'h0, e[1:0], 4'h0});
      for (int p = 1; p >= 0; p--) begin
        rd(frt_pkg::off_latched, a);
        capture_trigger_pin <= p[0];
        rd(frt_pkg::off_count, q);
        repeat (8) @(posedge mclk);
        rd(frt_pkg::off_latched, b);
        if (e[1 - p]) begin
          chk(b[15:0] - q[15:0] + 16'h0001 <= 16'h0002, "count captured");
        end else begin
          chk(b === a, "no capture");
        end
      end
    end
    $display("Capture test ended.");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(frt_pkg::off_count, q);
    chk(q[15:0] < 16'h0003 && shared_port_oe === 1'b0 && match_irq === 1'b0, "count after mid-run reset");
    $display("Mid-run reset test ended.");
    close_out();
  end
endmodule
`default_nettype wire
